// *** core/line_adapter_pkg.sv ***
// Shared constants for the RS-485 and infrared line adapter.
package line_adapter_pkg;

  // Register word indices on the plain register port.
  localparam logic [3:0] AUX_FEATURE_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h1;

  // Value of the auxiliary feature register after reset.
  localparam logic [7:0] AUX_FEATURE_RST = 8'h00;

  // Field positions inside the auxiliary feature register.
  localparam int INFRARED_BIT = 1;
  localparam int HALF_DUPLEX_BIT = 2;
  localparam int LARGE_BLOCK_BIT = 3;
  localparam int SNOOP_BIT = 4;
  localparam int DELAY_LSB = 5;
  localparam int DELAY_MSB = 7;

  // Field positions inside the status register.
  localparam int ST_ENABLE_BIT = 0;
  localparam int ST_HOLD_BIT = 1;
  localparam int ST_IR_TX_BIT = 2;
  localparam int ST_IR_RX_BIT = 3;
  localparam int ST_STORE_BIT = 4;

  // Longest post-transmit hold, in bit times.
  localparam logic [3:0] HOLD_MAX_BITS = 4'hf;

  // Counts of 16x baud ticks.
  localparam logic [3:0] TICKS_LAST = 4'hf;
  localparam logic [3:0] ENC_RISE_TICK = 4'h7;
  localparam logic [3:0] ENC_FALL_TICK = 4'ha;
  localparam logic [3:0] CNT_RST = 4'h0;

  // States of the transceiver-enable sequencer.
  typedef enum logic [1:0] {
    LINE_IDLE = 2'b00,
    LINE_DRIVE = 2'b01,
    LINE_HOLD = 2'b10
  } line_state_t;

endpackage : line_adapter_pkg

// *** core/rs485_irda_line_adapter.sv ***
// Line adapter: RS-485 enable, receive gating and infrared codec.
//
// Functional notes
// - Delay field sets post-transmit hold, bit times.
// - Hold starts when both transmit stages empty.
// - New holding write cancels hold, enable stays.
// - Enable rises one bit before first stop.
// - Enable stays high while transmit data pending.
// - Large-block: interrupt on empty or threshold cross.
// - Half-duplex, large-block cleared: interrupt on shifter empty.
// - Snoop set: store, threshold, timeout, error.
// - Normal, no snoop: store, no timeout interrupt.
// - Half-duplex or infrared, no snoop or loopback: store nothing.
// - Loopback always stores; timeout needs snoop.
// - Infrared codec is single-bit slow infrared.
// - Infrared bit is sixteen ticks; zero pulses.
// - High serial input keeps encoder output low.
// - Pulse from seventh to tenth tick.
// - Pulse repeats every bit while input low.
// - After reset decoder output high, counter clear.
// - Falling edge drives decoded output low sixteen ticks.
// - Without falling edges decoded output stays high.
// - Receiver samples mid-bit, ignoring short glitches.
// - Positive pulses decode on their trailing edge.
// - Bit one selects infrared mode.
// - Bit two half-duplex, bit three large block.
// - Half-duplex, no large block: interrupt on empty.
// - Bit four is snoop; in normal mode it still enables timeout.
//
// The register offsets and the plain strobed port were decided locally.

`timescale 1ns/1ps

module rs485_irda_line_adapter
  import line_adapter_pkg::*;
#(
  parameter int LEVEL_W = 7
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic baud_x16_tick_i,
  input wire logic internal_loopback_bit_i,
  input wire logic tx_shift_empty_i,
  input wire logic tx_fifo_empty_i,
  input wire logic tx_fifo_write_i,
  input wire logic tx_pre_stop_i,
  input wire logic [LEVEL_W-1:0] tx_fifo_level_i,
  input wire logic [LEVEL_W-1:0] tx_threshold_i,
  input wire logic serial_tx_i,
  input wire logic line_rx_i,
  output logic line_tx_o,
  output logic serial_rx_o,
  output logic transceiver_enable_out_o,
  output logic tx_irq_o,
  output logic rx_store_en_o,
  output logic rx_data_irq_en_o,
  output logic rx_timeout_irq_en_o
);

  // Software-visible feature register.
  logic [7:0] aux_feature_ctrl_q;
  // Decoded feature bits.
  logic infrared_mode_enable;
  logic half_duplex_line_enable;
  logic large_block_irq_mode;
  logic receiver_snoop_enable;
  logic [2:0] post_tx_hold_delay;
  // Hold length in bit times after the field is widened.
  logic [3:0] hold_bits;

  assign infrared_mode_enable = aux_feature_ctrl_q[INFRARED_BIT];
  assign half_duplex_line_enable =
    aux_feature_ctrl_q[HALF_DUPLEX_BIT];
  assign large_block_irq_mode = aux_feature_ctrl_q[LARGE_BLOCK_BIT];
  assign receiver_snoop_enable = aux_feature_ctrl_q[SNOOP_BIT];
  assign post_tx_hold_delay = aux_feature_ctrl_q[DELAY_MSB:DELAY_LSB];

  // Three bits cover 0 to 15 bit times: steps of two, top code at 15.
  assign hold_bits = (&post_tx_hold_delay) ? HOLD_MAX_BITS :
                     {post_tx_hold_delay, 1'b0};

  // Sequencer state and counters for the transceiver enable.
  line_state_t state_q, state_d;
  logic [3:0] hold_left_q, hold_left_d;
  logic [3:0] hold_sub_q, hold_sub_d;
  logic pending;

  // Transmit data sits in the shifter or the holding FIFO.
  assign pending = !tx_shift_empty_i || !tx_fifo_empty_i;

  // Software writes the feature register; it resets to all zeros.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      aux_feature_ctrl_q <= AUX_FEATURE_RST;
    end else if (clk_en_i && reg_wr_i && reg_addr_i == AUX_FEATURE_OFS) begin
      aux_feature_ctrl_q <= reg_wdata_i;
    end
  end

  // Read data appear one cycle after the strobe; unmapped reads give 0.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (clk_en_i) begin
      if (reg_rd_i && reg_addr_i == AUX_FEATURE_OFS) begin
        reg_rdata_o <= aux_feature_ctrl_q;
      end else if (reg_rd_i && reg_addr_i == STATUS_OFS) begin
        reg_rdata_o <= {3'b000, rx_store_en_o, serial_rx_o, line_tx_o,
                        state_q == LINE_HOLD, transceiver_enable_out_o};
      end else begin
        reg_rdata_o <= 8'h00;
      end
    end
  end

  // Next state of the enable sequencer.
  always_comb begin
    state_d = state_q;
    hold_left_d = hold_left_q;
    hold_sub_d = hold_sub_q;
    if (!half_duplex_line_enable) begin
      // Without half-duplex mode the enable is never driven.
      state_d = LINE_IDLE;
    end else begin
      case (state_q)
        LINE_IDLE: begin
          // Raise the enable one bit before the first stop bit.
          if (tx_pre_stop_i && pending) begin
            state_d = LINE_DRIVE;
          end
        end
        LINE_DRIVE: begin
          // Stay driving while anything is left to send.
          if (!pending && !tx_fifo_write_i) begin
            // Both stages empty: start the hold, or drop at once.
            hold_left_d = hold_bits;
            hold_sub_d = CNT_RST;
            state_d = (hold_bits == 4'h0) ? LINE_IDLE : LINE_HOLD;
          end
        end
        LINE_HOLD: begin
          if (tx_fifo_write_i || pending) begin
            // Fresh data cancels the hold; the enable stays high.
            state_d = LINE_DRIVE;
          end else if (baud_x16_tick_i) begin
            // One bit time passes every sixteen ticks.
            hold_sub_d = hold_sub_q + 4'h1;
            if (hold_sub_q == TICKS_LAST) begin
              hold_left_d = hold_left_q - 4'h1;
              if (hold_left_q == 4'h1) begin
                state_d = LINE_IDLE;
              end
            end
          end
        end
        default: begin
          state_d = LINE_IDLE;
        end
      endcase
    end
  end

  // Enable sequencer registers and the enable output flop.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      state_q <= LINE_IDLE;
      hold_left_q <= CNT_RST;
      hold_sub_q <= CNT_RST;
      transceiver_enable_out_o <= 1'b0;
    end else if (clk_en_i) begin
      state_q <= state_d;
      hold_left_q <= hold_left_d;
      hold_sub_q <= hold_sub_d;
      transceiver_enable_out_o <= (state_d != LINE_IDLE);
    end
  end

  // History for transmit interrupt edge detection.
  logic shift_empty_q;
  logic fifo_empty_q;
  logic above_seen_q;
  logic [LEVEL_W-1:0] level_q;
  logic std_irq_mode;
  logic fifo_drained;
  logic level_crossed;
  logic shift_drained;

  // Standard behaviour unless half-duplex without large block.
  assign std_irq_mode = !half_duplex_line_enable || large_block_irq_mode;
  assign fifo_drained = tx_fifo_empty_i && !fifo_empty_q;
  assign level_crossed = (level_q > tx_threshold_i) &&
                         (tx_fifo_level_i <= tx_threshold_i);
  assign shift_drained = tx_shift_empty_i && !shift_empty_q &&
                         tx_fifo_empty_i;

  // Transmit interrupt request, one cycle per event.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      shift_empty_q <= 1'b1;
      fifo_empty_q <= 1'b1;
      above_seen_q <= 1'b0;
      level_q <= '0;
      tx_irq_o <= 1'b0;
    end else if (clk_en_i) begin
      shift_empty_q <= tx_shift_empty_i;
      fifo_empty_q <= tx_fifo_empty_i;
      level_q <= tx_fifo_level_i;
      // A level above threshold wins over the clear on draining.
      if (tx_fifo_level_i > tx_threshold_i) begin
        above_seen_q <= 1'b1;
      end else if (fifo_drained) begin
        above_seen_q <= 1'b0;
      end
      if (std_irq_mode) begin
        // Empty without crossing, or a threshold crossing.
        tx_irq_o <= (fifo_drained && !above_seen_q) ||
                    level_crossed;
      end else begin
        // Held off until the shifter has gone empty.
        tx_irq_o <= shift_drained;
      end
    end
  end

  // Receive gating flops, set from loopback, mode and snoop.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rx_store_en_o <= 1'b1;
      rx_data_irq_en_o <= 1'b1;
      rx_timeout_irq_en_o <= 1'b0;
    end else if (clk_en_i) begin
      // Half-duplex or infrared without snoop or loopback stores nothing.
      rx_store_en_o <= internal_loopback_bit_i || receiver_snoop_enable ||
        !(half_duplex_line_enable || infrared_mode_enable);
      rx_data_irq_en_o <= internal_loopback_bit_i ||
        receiver_snoop_enable ||
        !(half_duplex_line_enable || infrared_mode_enable);
      // The timeout interrupt is only offered while snoop is set.
      rx_timeout_irq_en_o <= receiver_snoop_enable;
    end
  end

  // Infrared encoder: tick counter and pulse window.
  logic [3:0] enc_cnt_q;
  logic [3:0] enc_cnt_d;
  logic enc_pulse;

  // Count ticks within each bit while the serial input is low.
  assign enc_cnt_d = serial_tx_i ? CNT_RST :
                     (baud_x16_tick_i ? enc_cnt_q + 4'h1 : enc_cnt_q);
  assign enc_pulse = !serial_tx_i && (enc_cnt_d >= ENC_RISE_TICK) &&
                     (enc_cnt_d < ENC_FALL_TICK);

  // Encoder counter and line transmit output.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      enc_cnt_q <= CNT_RST;
      line_tx_o <= 1'b0;
    end else if (clk_en_i) begin
      // The counter wraps every sixteen ticks, one bit time.
      enc_cnt_q <= enc_cnt_d;
      // Infrared mode sends pulses; otherwise the bit passes through.
      line_tx_o <= infrared_mode_enable ? enc_pulse : serial_tx_i;
    end
  end

  // Infrared decoder: edge detector, tick counter and low flag.
  logic rx_prev_q;
  logic dec_low_q;
  logic [3:0] dec_cnt_q;
  logic rx_fall;

  // Only falling edges count, so positive pulses end a zero late.
  assign rx_fall = rx_prev_q && !line_rx_i;

  // Decoder state; a new edge restarts the sixteen tick window.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rx_prev_q <= 1'b1;
      dec_low_q <= 1'b0;
      dec_cnt_q <= CNT_RST;
    end else if (clk_en_i) begin
      rx_prev_q <= line_rx_i;
      if (rx_fall) begin
        dec_low_q <= 1'b1;
        dec_cnt_q <= CNT_RST;
      end else if (dec_low_q && baud_x16_tick_i) begin
        dec_cnt_q <= dec_cnt_q + 4'h1;
        if (dec_cnt_q == TICKS_LAST) begin
          dec_low_q <= 1'b0;
        end
      end
    end
  end

  // Serial data toward the receiver; mid-bit sampling there hides the
  // one-tick high gap that jitter can leave between zeros.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      serial_rx_o <= 1'b1;
    end else if (clk_en_i) begin
      if (infrared_mode_enable) begin
        serial_rx_o <= !(rx_fall || (dec_low_q && !(baud_x16_tick_i &&
                       dec_cnt_q == TICKS_LAST)));
      end else begin
        serial_rx_o <= line_rx_i;
      end
    end
  end

  // Checks on the adapter's own outputs.
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_no_store;
    clk_en_i && half_duplex_line_enable && !receiver_snoop_enable &&
      !internal_loopback_bit_i |=> !rx_store_en_o && !rx_data_irq_en_o;
  endproperty
  a_no_store: assert property (p_no_store)
    else $error("receive stored without snoop in half duplex");

  property p_normal_no_timeout;
    clk_en_i && !half_duplex_line_enable && !infrared_mode_enable &&
      !receiver_snoop_enable && !internal_loopback_bit_i
      |=> rx_store_en_o && rx_data_irq_en_o && !rx_timeout_irq_en_o;
  endproperty
  a_normal_no_timeout: assert property (p_normal_no_timeout)
    else $error("normal mode gating wrong");

  property p_snoop_all;
    clk_en_i && receiver_snoop_enable
      |=> rx_store_en_o && rx_data_irq_en_o && rx_timeout_irq_en_o;
  endproperty
  a_snoop_all: assert property (p_snoop_all)
    else $error("snoop set but receive path gated");

  property p_loop_store;
    clk_en_i && internal_loopback_bit_i |=> rx_store_en_o;
  endproperty
  a_loop_store: assert property (p_loop_store)
    else $error("loopback did not store");

  property p_enc_idle;
    clk_en_i && infrared_mode_enable && serial_tx_i |=> !line_tx_o;
  endproperty
  a_enc_idle: assert property (p_enc_idle)
    else $error("encoder pulsed on high input");

  property p_dec_fall;
    clk_en_i && infrared_mode_enable && rx_fall |=> !serial_rx_o;
  endproperty
  a_dec_fall: assert property (p_dec_fall)
    else $error("decoder missed falling edge");

  property p_hold_cancel;
    clk_en_i && half_duplex_line_enable && state_q == LINE_HOLD &&
      tx_fifo_write_i |=> transceiver_enable_out_o ##0
      state_q == LINE_DRIVE;
  endproperty
  a_hold_cancel: assert property (p_hold_cancel)
    else $error("write did not cancel hold");

  property p_pending_high;
    clk_en_i && half_duplex_line_enable && transceiver_enable_out_o &&
      pending |=> transceiver_enable_out_o;
  endproperty
  a_pending_high: assert property (p_pending_high)
    else $error("enable dropped with data pending");

  property p_hd_irq_held;
    clk_en_i && half_duplex_line_enable && !large_block_irq_mode &&
      !tx_shift_empty_i |=> !tx_irq_o;
  endproperty
  a_hd_irq_held: assert property (p_hd_irq_held)
    else $error("transmit interrupt before shifter empty");

  c_hold_done: cover property (state_q == LINE_HOLD ##1
    state_q == LINE_IDLE);
  c_ir_pulse: cover property ($rose(line_tx_o) && infrared_mode_enable);
  c_dec_low: cover property ($fell(serial_rx_o) && infrared_mode_enable);
  c_lg_irq: cover property (tx_irq_o && large_block_irq_mode);

endmodule : rs485_irda_line_adapter

// *** tb/optics_model.sv ***
// Infrared optics that send one zero pulse on request.
`timescale 1ns/1ps
module optics_model (
  input wire logic core_clk_i,
  input wire logic baud_x16_tick_i,
  input wire logic send_zero_i,
  input wire logic positive_i,
  output logic line_rx_o
);
  logic [4:0] tick_q = 5'h10; // Ticks into the bit; 16 means dark.
  logic light; // Light falls on the diode during ticks 7 to 9.
  // A zero bit is one short flash, a one bit is darkness.
  always_ff @(posedge core_clk_i) begin
    if (send_zero_i) begin
      tick_q <= 5'h00;
    end else if (baud_x16_tick_i && tick_q != 5'h10) begin
      tick_q <= tick_q + 5'h01;
    end
  end
  assign light = (tick_q >= 5'h07) && (tick_q < 5'h0a);
  // The diode stage may or may not invert, so both polarities occur.
  assign line_rx_o = positive_i ? light : !light;
endmodule : optics_model

// *** tb/rs485_irda_line_adapter_tb.sv ***
// Self-checking bench for the RS-485 and infrared line adapter.
`timescale 1ns/1ps
module rs485_irda_line_adapter_tb;
  import line_adapter_pkg::*;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic clk_en = 1'b1; // Clock enable; low freezes the adapter.
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic tick = 1'b0; // 16x baud pulse, one cycle in four.
  logic [1:0] div = 2'h0;
  logic loop = 1'b0;
  logic sh_empty = 1'b1;
  logic fi_empty = 1'b1;
  logic fi_write = 1'b0;
  logic pre_stop = 1'b0;
  logic [6:0] level = 7'h00;
  logic [6:0] tx_holding_fifo = 7'h10;
  logic ser_tx = 1'b1;
  logic send_zero = 1'b0;
  logic positive = 1'b0;
  logic line_rx, line_tx, ser_rx, drv_en, tx_irq, store, data_irq, tmo;
  logic [7:0] codes [6] = '{8'h10, 8'h14, 8'h12, 8'h00, 8'h04, 8'h02};
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;

  rs485_irda_line_adapter i_rs485_irda_line_adapter (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .baud_x16_tick_i(tick),
    .internal_loopback_bit_i(loop), .tx_shift_empty_i(sh_empty),
    .tx_fifo_empty_i(fi_empty), .tx_fifo_write_i(fi_write),
    .tx_pre_stop_i(pre_stop), .tx_fifo_level_i(level),
    .tx_threshold_i(tx_holding_fifo), .serial_tx_i(ser_tx), .line_rx_i(line_rx),
    .line_tx_o(line_tx), .serial_rx_o(ser_rx),
    .transceiver_enable_out_o(drv_en), .tx_irq_o(tx_irq),
    .rx_store_en_o(store), .rx_data_irq_en_o(data_irq),
    .rx_timeout_irq_en_o(tmo));

  optics_model i_optics_model (.core_clk_i(core_clk_i),
    .baud_x16_tick_i(tick), .send_zero_i(send_zero),
    .positive_i(positive), .line_rx_o(line_rx));

  // Clock at 25 ns period.
  initial begin
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  // Baud tick generator and hang guard.
  always @(posedge core_clk_i) begin
    div <= div + 2'h1;
    tick <= (div == 2'h3);
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic cmp(input string name, input logic [7:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp

  task automatic report_and_stop();
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk_i);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe.
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
    @(posedge core_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk_i);
    rd <= 1'b0;
    #1 cmp("reg read", exp, rdata);
  endtask : rd_reg

  task automatic tk(input int n);
    repeat (n) @(posedge core_clk_i iff tick);
  endtask : tk

  // The interrupt is a one-cycle pulse, so it is caught in a window.
  task automatic expect_irq(input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (4) begin
      @(posedge core_clk_i);
      #1 seen = seen | tx_irq;
    end
    cmp("tx_irq", {7'h0, exp}, {7'h0, seen});
  endtask : expect_irq

  // Sends pending data, empties both stages and times the hold.
  task automatic hold_run(input logic [2:0] code, input bit cancel);
    int n;
    logic [7:0] exp;
    exp = (code == 3'h7) ? 8'hf0 : {code, 5'h00};
    wr_reg(AUX_FEATURE_OFS, {code, 5'h04});
    sh_empty <= 1'b0;
    fi_empty <= 1'b0;
    tk(2);
    cmp("enable idle", 8'h00, {7'h0, drv_en});
    pre_stop <= 1'b1;
    @(posedge core_clk_i);
    pre_stop <= 1'b0;
    #1 cmp("enable up", 8'h01, {7'h0, drv_en});
    tk(20);
    cmp("enable pending", 8'h01, {7'h0, drv_en});
    sh_empty <= 1'b1;
    fi_empty <= 1'b1;
    if (cancel) begin
      tk(5);
      // Status shows the enable, a running hold and idle lines.
      rd_reg(STATUS_OFS, 8'h0f);
      fi_write <= 1'b1;
      fi_empty <= 1'b0;
      @(posedge core_clk_i);
      fi_write <= 1'b0;
      tk(60);
      cmp("enable kept", 8'h01, {7'h0, drv_en});
      fi_empty <= 1'b1;
    end
    n = 0;
    while (drv_en === 1'b1 && n < 300) begin
      @(posedge core_clk_i);
      if (tick && drv_en) n++;
    end
    cmp("hold ticks", exp, n[7:0]);
  endtask : hold_run

  // Times the decoded zero that one optical pulse produces.
  task automatic decode(input logic pos);
    int n;
    positive <= pos;
    tk(40);
    send_zero <= 1'b1;
    @(posedge core_clk_i);
    send_zero <= 1'b0;
    n = 0;
    while (ser_rx !== 1'b0 && n < 200) begin
      @(posedge core_clk_i);
      n++;
    end
    n = 0;
    while (ser_rx === 1'b0 && n < 40) begin
      if (tick) n++;
      @(posedge core_clk_i);
    end
    cmp("decoded zero", 8'h10, n[7:0]);
    tk(30);
    cmp("decoded idle", 8'h01, {7'h0, ser_rx});
  endtask : decode

  // Main sequence.
  initial begin
    logic e;
    repeat (20) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge core_clk_i);
    #1 cmp("decoder reset", 8'h01, {7'h0, ser_rx});
    cmp("enable reset", 8'h00, {7'h0, drv_en});
    rd_reg(AUX_FEATURE_OFS, AUX_FEATURE_RST);
    wr_reg(AUX_FEATURE_OFS, 8'hb6);
    rd_reg(AUX_FEATURE_OFS, 8'hb6);
    // A write strobe while the clock enable is low must be ignored.
    clk_en <= 1'b0;
    wr_reg(AUX_FEATURE_OFS, 8'h55);
    clk_en <= 1'b1;
    rd_reg(AUX_FEATURE_OFS, 8'hb6);
    rd_reg(STATUS_OFS, 8'h18);
    wr_reg(4'h7, 8'hff);
    rd_reg(4'h7, 8'h00);
    // Transmit interrupt in its three settings.
    wr_reg(AUX_FEATURE_OFS, 8'h0c);
    fi_empty <= 1'b0;
    level <= 7'h05;
    expect_irq(1'b0);
    fi_empty <= 1'b1;
    level <= 7'h00;
    expect_irq(1'b1);
    wr_reg(AUX_FEATURE_OFS, 8'h00);
    fi_empty <= 1'b0;
    level <= 7'h14;
    expect_irq(1'b0);
    level <= 7'h0a;
    expect_irq(1'b1);
    wr_reg(AUX_FEATURE_OFS, 8'h04);
    sh_empty <= 1'b0;
    level <= 7'h00;
    expect_irq(1'b0);
    fi_empty <= 1'b1;
    expect_irq(1'b0);
    sh_empty <= 1'b1;
    expect_irq(1'b1);
    // Transceiver enable with zero, cancelled and longest hold.
    hold_run(3'h0, 1'b0);
    hold_run(3'h1, 1'b1);
    hold_run(3'h7, 1'b0);
    // Receive gating over every mode, loopback off and on.
    for (int l = 0; l < 2; l++) begin
      foreach (codes[i]) begin
        loop <= l[0];
        wr_reg(AUX_FEATURE_OFS, codes[i]);
        tk(1);
        e = l[0] | codes[i][SNOOP_BIT] |
          !(codes[i][HALF_DUPLEX_BIT] | codes[i][INFRARED_BIT]);
        #1 cmp("rx gating", {5'h0, e, e, codes[i][SNOOP_BIT]},
          {5'h0, store, data_irq, tmo});
      end
    end
    loop <= 1'b0;
    // Infrared encoder over two low bits, then idle.
    wr_reg(AUX_FEATURE_OFS, 8'h02);
    tk(1);
    ser_tx <= 1'b0;
    for (int k = 1; k <= 32; k++) begin
      tk(1);
      repeat (2) @(posedge core_clk_i);
      e = (k % 16) >= 7 && (k % 16) <= 9;
      #1 cmp("ir pulse", {7'h0, e}, {7'h0, line_tx});
    end
    ser_tx <= 1'b1;
    for (int k = 0; k < 16; k++) begin
      tk(1);
      #1 cmp("ir dark", 8'h00, {7'h0, line_tx});
    end
    decode(1'b0);
    decode(1'b1);
    report_and_stop();
  end
endmodule : rs485_irda_line_adapter_tb
